//--- design/rbs_regs.vh
// constants for the reset and boot sequencer
`ifndef RBS_REGS_VH
`define RBS_REGS_VH
// cycle counts on the oscillator clock
`define RBS_RST_MIN_CYC 8
`define RBS_WD_PULSE_CYC 512
`define RBS_EXEC_DELAY_CYC 32
`define RBS_BOOT_HOLD_CYC 200
// edges from a pin release to internal release: two sync stages plus one state step
`define RBS_SYNC_LAT 3
// divider field reset value and width
`define RBS_CLKOUT_DIV_RESET 2'h0
`define RBS_CLKOUT_DIV_W 2
`define RBS_BOOT_W 4
`define RBS_CNT_W 10
`endif

//--- design/rbs_clock_divider.v
// divider that makes the core clock enable and the clock output pin level
`timescale 1ns/1ps
module rbs_clock_divider (
    input wire clock,
    input wire rst_n,
    input wire core_div_one,
    input wire [1:0] out_div_sel,
    output reg core_system_clock_en,
    output reg clock_output_pin
);
    // ==========================================
    // core enable: every second cycle unless software picks divide by one
    reg half_phase;
    reg [2:0] out_cnt;
    reg [2:0] out_half;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            half_phase <= 1'b0;
            core_system_clock_en <= 1'b0;
        end else begin
            half_phase <= ~half_phase;
            core_system_clock_en <= core_div_one | half_phase;
        end
    end
    // field 0 gives core/4, 1 gives core/2, else core/1 while the core runs at half rate
    always @* begin
        case (out_div_sel)
            2'h0: out_half = 3'h1;
            2'h1: out_half = 3'h0;
            default: out_half = 3'h0;
        endcase
    end
    // ==========================================
    // output pin toggles after out_half+1 core enables
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_cnt <= 3'h0;
            clock_output_pin <= 1'b0;
        end else if (out_div_sel == 2'h2 || out_div_sel == 2'h3) begin
            clock_output_pin <= core_system_clock_en; // pulse form; with the core at full rate the enable stays high and so does the pin
            out_cnt <= 3'h0;
        end else if (core_system_clock_en) begin
            if (out_cnt >= out_half) begin
                out_cnt <= 3'h0;
                clock_output_pin <= ~clock_output_pin;
            end else begin
                out_cnt <= out_cnt + 3'h1;
            end
        end
    end
endmodule // rbs_clock_divider

//--- design/rbs_reset_boot_sequencer.v
// reset qualification, watchdog reset pulse, start delay and boot pin sampling
// ==========================================
// Notes on behaviour
// - core clock runs at oscillator half after power-on
// - output divider field resets zero, core/4
// - watchdog reset drives pin low 512 cycles
// - execution starts 32 cycles after pin release
// - boot pins sampled when execution starts
`timescale 1ns/1ps
`include "rbs_regs.vh"
module rbs_reset_boot_sequencer (
    input wire clock,
    input wire rst_n,
    input wire external_reset_pin_n_in,
    output reg external_reset_pin_n_out,
    output reg external_reset_pin_n_oe,
    input wire watchdog_reset_req,
    input wire [`RBS_BOOT_W-1:0] boot_mode_pins,
    input wire core_div_one,
    input wire [`RBS_CLKOUT_DIV_W-1:0] clock_output_divider_field,
    input wire clock_output_divider_wr,
    output reg core_reset_n,
    output reg exec_start,
    output reg boot_mode_valid,
    output reg [`RBS_BOOT_W-1:0] boot_mode,
    output wire core_system_clock_en,
    output wire clock_output_pin
);
    localparam ST_RESET = 2'h0;
    localparam ST_DELAY = 2'h1;
    localparam ST_RUN = 2'h2;
    // full pulse length loaded into the counter, sized to the counter
    localparam [`RBS_CNT_W-1:0] WD_LOAD = `RBS_WD_PULSE_CYC;
    reg pin_s1;
    reg pin_s2;
    reg [`RBS_BOOT_W-1:0] boot_s1;
    reg [`RBS_BOOT_W-1:0] boot_s2;
    reg [1:0] state;
    reg [`RBS_CNT_W-1:0] cnt;
    reg [`RBS_CNT_W-1:0] wd_cnt;
    reg [`RBS_CLKOUT_DIV_W-1:0] div_field;
    // ==========================================
    // two-stage synchronisers for the pin inputs
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            boot_s1 <= {`RBS_BOOT_W{1'b0}};
            boot_s2 <= {`RBS_BOOT_W{1'b0}};
        end else begin
            pin_s1 <= external_reset_pin_n_in;
            pin_s2 <= pin_s1;
            boot_s1 <= boot_mode_pins;
            boot_s2 <= boot_s1;
        end
    end
    // ==========================================
    // watchdog pulse: drive the pin low for the nominal width
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt <= {`RBS_CNT_W{1'b0}};
            external_reset_pin_n_out <= 1'b0;
            external_reset_pin_n_oe <= 1'b0;
        end else if (wd_cnt != {`RBS_CNT_W{1'b0}}) begin
            wd_cnt <= wd_cnt - 1'b1;
            external_reset_pin_n_oe <= (wd_cnt != 10'h001);
        end else if (watchdog_reset_req && !external_reset_pin_n_oe) begin
            wd_cnt <= WD_LOAD;
            external_reset_pin_n_oe <= 1'b1;
        end else begin
            external_reset_pin_n_oe <= 1'b0;
        end
    end
    // ==========================================
    // reset / start-delay sequence; a low pin always forces back to reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RESET;
            cnt <= {`RBS_CNT_W{1'b0}};
            core_reset_n <= 1'b0;
            exec_start <= 1'b0;
            boot_mode_valid <= 1'b0;
            boot_mode <= {`RBS_BOOT_W{1'b0}};
        end else begin
            exec_start <= 1'b0;
            if (!pin_s2) begin
                // short glitches also reset; the pin owner keeps the 8-cycle minimum
                state <= ST_RESET;
                core_reset_n <= 1'b0;
                boot_mode_valid <= 1'b0;
                cnt <= {`RBS_CNT_W{1'b0}};
            end else begin
                case (state)
                    ST_RESET: begin
                        state <= ST_DELAY;
                        core_reset_n <= 1'b1;
                        cnt <= {`RBS_CNT_W{1'b0}};
                    end
                    ST_DELAY: begin
                        cnt <= cnt + 1'b1;
                        // sync latency is taken off so the delay is measured from the pin
                        if (cnt == `RBS_EXEC_DELAY_CYC - `RBS_SYNC_LAT - 1) begin
                            state <= ST_RUN;
                            exec_start <= 1'b1;
                            // boot pins still held by the board at this point
                            boot_mode <= boot_s2;
                            boot_mode_valid <= 1'b1;
                        end
                    end
                    ST_RUN: state <= ST_RUN;
                    default: state <= ST_RESET;
                endcase
            end
        end
    end
    // ==========================================
    // clock output divider field, cleared by any reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_field <= `RBS_CLKOUT_DIV_RESET;
        end else if (!core_reset_n) begin
            div_field <= `RBS_CLKOUT_DIV_RESET;
        end else if (clock_output_divider_wr) begin
            div_field <= clock_output_divider_field;
        end
    end
    rbs_clock_divider u_div (
        .clock(clock),
        .rst_n(rst_n),
        .core_div_one(core_div_one & core_reset_n),
        .out_div_sel(div_field),
        .core_system_clock_en(core_system_clock_en),
        .clock_output_pin(clock_output_pin)
    );
endmodule // rbs_reset_boot_sequencer

//--- tb/rbs_supervisor_model.sv
// board supervisor: open-drain reset pin with pull-up, boot strap pins
`timescale 1ns/1ps
module rbs_supervisor_model (
    input wire hold_n,
    input wire clock,
    input wire [3:0] sel,
    input wire dut_out,
    input wire dut_oe,
    output wire pin_n,
    output wire [3:0] boot
);
    int up;
    // pull-up wins only when nobody pulls low; bench keeps hold_n low 8+ cycles
    assign pin_n = hold_n && !(dut_oe && !dut_out);
    // straps hold 200 cycles past release, then wander so a late sample shows
    always @(posedge clock) up <= pin_n ? up + 1 : 0;
    assign boot = (up < 200) ? sel : ~sel ^ 4'(up);
endmodule // rbs_supervisor_model

//--- tb/rbs_assertions.sv
// concurrent checks on the reset and boot sequencer ports
`timescale 1ns/1ps
module rbs_assertions (
    input wire clock,
    input wire rst_n,
    input wire external_reset_pin_n_in,
    input wire external_reset_pin_n_out,
    input wire external_reset_pin_n_oe,
    input wire watchdog_reset_req,
    input wire core_div_one,
    input wire [1:0] clock_output_divider_field,
    input wire clock_output_divider_wr,
    input wire core_reset_n,
    input wire exec_start,
    input wire boot_mode_valid,
    input wire core_system_clock_en,
    input wire clock_output_pin
);
    // ==========================
    // shadow of the divider field, cleared by internal reset
    logic [1:0] fld;
    wire oe = external_reset_pin_n_oe;
    always @(posedge clock or negedge rst_n)
        if (!rst_n || !core_reset_n) fld <= 2'h0;
        else if (clock_output_divider_wr) fld <= clock_output_divider_field;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    pin_sync_a: assert property (!external_reset_pin_n_in |-> ##[0:3] !core_reset_n)
        else $error("pin low ignored");
    exec_delay_a: assert property ($rose(core_reset_n) |-> ##29 exec_start)
        else $error("start delay wrong");
    boot_valid_a: assert property (exec_start |-> boot_mode_valid)
        else $error("boot mode not valid");
    wd_start_a: assert property (watchdog_reset_req && !oe |=> oe)
        else $error("watchdog pulse missing");
    wd_width_a: assert property ($fell(oe) |-> $past(oe, 512) && !$past(oe, 513))
        else $error("watchdog pulse width");
    pin_low_a: assert property (oe |-> !external_reset_pin_n_out)
        else $error("pin not driven low");
    core_half_a: assert property (!core_div_one && !$past(core_div_one) && core_system_clock_en
        |=> !core_system_clock_en) else $error("core not halved");
    out_div_a: assert property (fld == 2'h0 && !core_div_one && $rose(clock_output_pin)
        |-> clock_output_pin[*4] ##1 !clock_output_pin) else $error("output not osc/8");
    cover property (exec_start);
    cover property ($fell(oe));
    cover property (clock_output_divider_wr);
endmodule // rbs_assertions
bind rbs_reset_boot_sequencer rbs_assertions u_chk (.*);

//--- tb/reset_boot_clock_sequencer_bench.sv
// self-checking bench for the reset and boot sequencer
`timescale 1ns/1ps
module reset_boot_clock_sequencer_bench;
    logic clock = 0, rst_n = 0, hold_n = 0, watchdog_reset_req = 0, core_div_one = 0;
    logic clock_output_divider_wr = 0, external_reset_pin_n_out, external_reset_pin_n_oe;
    logic [1:0] clock_output_divider_field = 2'h0;
    logic [3:0] sel = 4'h0, boot_mode_pins, boot_mode, q[$];
    logic external_reset_pin_n_in, core_reset_n, exec_start, boot_mode_valid;
    logic core_system_clock_en, clock_output_pin;
    int error_cnt = 0, total_checks = 0, cyc = 0, n;
    rbs_reset_boot_sequencer u_dut (.*);
    rbs_supervisor_model u_sup (.clock, .hold_n, .sel, .dut_out(external_reset_pin_n_out),
        .dut_oe(external_reset_pin_n_oe), .pin_n(external_reset_pin_n_in), .boot(boot_mode_pins));
    // ==========================
    initial forever #5 clock = ~clock;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hold the pin low, release it, time the first execution from the release
    task boot(input logic [3:0] s);
        @(negedge clock);
        hold_n = 0;
        sel = s;
        q.push_back(s);
        repeat (8) @(negedge clock);
        hold_n = 1;
        n = 0;
        while (!exec_start) begin
            @(posedge clock);
            #1 n++;
        end
        check(n, 32);
        $display("boot test ended");
    endtask
    // cycles between rising edges of the clock output pin
    task period(input int exp);
        realtime t;
        @(posedge clock_output_pin) t = $realtime;
        @(posedge clock_output_pin) check(($realtime - t) / 10, exp);
    endtask
    // the oldest expected boot mode is taken at each start of execution
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin error_cnt++; stop_test; end
        if (exec_start) check(boot_mode, q.size() ? q.pop_front() : 4'hx);
    end
    initial begin
        void'($urandom(32'h1a43));
        repeat (10) @(negedge clock);
        rst_n = 1;
        repeat (5) boot(4'($urandom));
        n = 0;
        repeat (16) begin @(posedge clock); #1 n += core_system_clock_en; end
        check(n, 8);
        period(8);
        // a held request must not stretch the 512-cycle pulse
        @(negedge clock);
        watchdog_reset_req = 1;
        q.push_back(sel);
        n = 0;
        fork
            begin
                repeat ($urandom_range(2, 20)) @(negedge clock);
                watchdog_reset_req = 0;
            end
            begin
                @(posedge clock);
                #1;
                while (external_reset_pin_n_oe) begin
                    n++;
                    @(posedge clock);
                    #1;
                end
            end
        join
        check(n, 512);
        wait (q.size() == 0);
        $display("watchdog test ended");
        // every field value with core at half rate, fields 0 and 1 with core at full rate
        for (int i = 0; i < 6; i++) begin
            // write just after a fall so no high phase straddles a field change
            @(negedge clock_output_pin);
            @(negedge clock);
            clock_output_divider_field = 2'(i);
            core_div_one = i > 3;
            clock_output_divider_wr = 1;
            @(negedge clock);
            clock_output_divider_wr = 0;
            repeat (16) @(negedge clock);
            period(i == 0 ? 8 : i == 1 || i == 4 ? 4 : 2);
        end
        $display("divider test ended");
        stop_test;
    end
endmodule // reset_boot_clock_sequencer_bench
